// ---- test/bus_partner.sv ----
// bus-side partner: arbiter grant and read-data receiver with optional stalls
`timescale 1ns/1ps
module bus_partner (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       request_i,
  input  wire logic [3:0] grant_delay_i,
  input  wire logic       stall_i,
  output logic            grant_o,
  output logic            ready_o
);
  logic [3:0] wait_cnt;
  logic       phase;

  always_ff @(posedge clk_i) begin
    if (reset_i || !request_i) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt != grant_delay_i) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
    phase <= reset_i ? 1'b0 : !phase;
  end

  // grant stays up while the request stands, so the synchronised copy cannot miss it
  assign grant_o = request_i && (wait_cnt == grant_delay_i);
  // a slow receiver takes a beat only every other cycle
  assign ready_o = !stall_i || phase;
endmodule // bus_partner

// ---- test/l2_cache_transaction_response_tb.sv ----
// self-checking bench for the cache transaction response logic
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module l2_cache_transaction_response_tb;
  import l2_resp_pkg::*;
  localparam logic [12:0] K_FL = 13'h1000, K_CL = 13'h0800, K_IV = 13'h0400, K_UP = 13'h0200;
  localparam logic [12:0] K_CD = 13'h0100, K_RQ = 13'h0040, K_FC = 13'h0008, K_CS = 13'h0010;
  localparam logic [12:0] K_RS = 13'h0004, K_CO = 13'h0002, K_AB = 13'h0001;
  localparam logic [12:0] K_PUSH = 13'h00e0;
  logic clk_i, reset_i, transfer_start_i, burst_flag_n_i, cache_inhibit_n_i, write_through_n_i;
  logic tag_hit_i, tag_dirty_i, castout_hit_i, castout_full_i, victim_dirty_i, snoop_prev_i;
  logic snoop_was_read_i, snoop_was_hit_i, address_retry_i, data_bus_busy_i, bus_grant_i;
  logic receiver_ready_i, stall, hit_claim_o, address_acknowledge_o, transfer_acknowledge_o;
  logic address_retry_o, cache_bus_request_o, line_fill_o, invalidate_o, update_o;
  logic clear_dirty_o, writeback_o, castout_supply_o, fill_cancel_o, restore_victim_o;
  logic castout_invalidate_o, read_abort_o, cb_burst_flag_n_o, cb_cache_inhibit_n_o;
  logic cb_write_through_n_o, cb_drive_o, data_valid_o;
  logic [TT_W-1:0] transfer_type_code_i, cb_type_code_o, tt;
  logic [63:0]     read_data_i, data_o, last_data;
  logic [3:0]      grant_delay;
  logic [12:0]     seen, care;
  int              failures, n_compared, n_xack, n_addr_ack, n_beats, cycles;

  l2_cache_transaction_response dut (.clk_i, .reset_i, .transfer_start_i,
    .transfer_type_code_i, .burst_flag_n_i, .cache_inhibit_n_i, .write_through_n_i,
    .tag_hit_i, .tag_dirty_i, .castout_hit_i, .castout_full_i, .victim_dirty_i,
    .snoop_prev_i, .snoop_was_read_i, .snoop_was_hit_i, .address_retry_i, .data_bus_busy_i,
    .bus_grant_i, .read_data_i, .receiver_ready_i, .hit_claim_o, .address_acknowledge_o,
    .transfer_acknowledge_o, .address_retry_o, .cache_bus_request_o, .line_fill_o,
    .invalidate_o, .update_o, .clear_dirty_o, .writeback_o, .castout_supply_o,
    .fill_cancel_o, .restore_victim_o, .castout_invalidate_o, .read_abort_o,
    .cb_type_code_o, .cb_burst_flag_n_o, .cb_cache_inhibit_n_o, .cb_write_through_n_o,
    .cb_drive_o, .data_o, .data_valid_o);

  bus_partner partner (.clk_i, .reset_i, .request_i(cache_bus_request_o),
    .grant_delay_i(grant_delay), .stall_i(stall), .grant_o(bus_grant_i),
    .ready_o(receiver_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // collects every response seen during a transaction window
  always @(posedge clk_i) begin
    seen = seen | {line_fill_o, hit_claim_o, invalidate_o, update_o, clear_dirty_o,
      address_retry_o, cache_bus_request_o, writeback_o, castout_supply_o, fill_cancel_o,
      restore_victim_o, castout_invalidate_o, read_abort_o};
    if (transfer_acknowledge_o === 1'b1) n_xack++;
    if (address_acknowledge_o === 1'b1) n_addr_ack++;
    `CHK(cb_drive_o, writeback_o)
    // data_valid_o already marks a word taken by the receiver
    if (data_valid_o === 1'b1) begin
      n_beats++;
      last_data = data_o;
    end
    cycles++;
    if (cycles == 6000) begin
      failures++;
      final_report();
    end
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // window is long enough for a slow grant plus the write-back that follows it
  task automatic run(input logic [4:0] code, input logic [2:0] atr, input logic [1:0] tag,
                     input logic [12:0] exp);
    @(posedge clk_i);
    #1;
    transfer_type_code_i = code;
    {burst_flag_n_i, cache_inhibit_n_i, write_through_n_i} = atr;
    {tag_hit_i, tag_dirty_i} = tag;
    seen = 13'h0000;
    {n_xack, n_addr_ack, n_beats} = '0;
    transfer_start_i = 1'b1;
    repeat (30) @(posedge clk_i);
    #1;
    transfer_start_i = 1'b0;
    `CHK(seen & care, exp & care)
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  // castout hit, full, victim dirty, snoop prev, snoop read, snoop hit, retry
  task automatic ctx(input logic [6:0] v);
    {castout_hit_i, castout_full_i, victim_dirty_i, snoop_prev_i, snoop_was_read_i,
     snoop_was_hit_i, address_retry_i} = v;
  endtask

  initial begin
    reset_i = 1'b1;
    transfer_start_i = 1'b0;
    transfer_type_code_i = 5'h00;
    {burst_flag_n_i, cache_inhibit_n_i, write_through_n_i} = 3'h7;
    {tag_hit_i, tag_dirty_i} = 2'h0;
    ctx(7'h00);
    data_bus_busy_i = 1'b0;
    read_data_i = 64'h0123_4567_89ab_cdef;
    {stall, grant_delay, care, seen} = {1'b0, 4'h0, 13'h1fff, 13'h0000};
    {failures, n_compared, cycles} = '0;
    repeat (5) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    `CHK({cb_type_code_o, cb_burst_flag_n_o, cb_cache_inhibit_n_o, cb_write_through_n_o}, 8'h07)
    for (int i = 0; i < 4; i++) begin
      stall = i[0];
      tt = TT_READ_VAL | {i[1], 1'b0, i[0], 2'b00};
      run(tt, 3'b011, 2'b00, K_FL);
      run(tt, 3'b011, 2'b10, K_CL);
      `CHK({n_xack, n_addr_ack, n_beats}, {32'h4, 32'h1, 32'h4})
      `CHK(last_data, 64'h0123_4567_89ab_cdef)
    end
    run(TT_READ_VAL, 3'b111, 2'b00, 13'h0000);
    $display("test reads done");
    run(TT_NCRD_VAL, 3'b101, 2'b10, K_IV);
    run(5'h1a, 3'b101, 2'b11, K_PUSH | K_IV);
    grant_delay = 4'h8;
    run(TT_BWR_VAL, 3'b011, 2'b00, K_FL);
    run(TT_WT_VAL, 3'b110, 2'b10, K_UP);
    run(TT_BWR_VAL, 3'b010, 2'b10, K_UP);
    run(TT_BWR_VAL, 3'b010, 2'b11, K_UP | K_CD);
    run(TT_SWR_VAL, 3'b110, 2'b11, K_PUSH | K_CD);
    `CHK({cb_type_code_o, cb_burst_flag_n_o, cb_cache_inhibit_n_o, cb_write_through_n_o}, 8'h13)
    run(TT_NCWR_VAL, 3'b100, 2'b10, K_IV);
    run(5'h12, 3'b100, 2'b11, K_PUSH | K_IV);
    run(TT_FLUSH_VAL, 3'b000, 2'b10, K_IV);
    run(TT_FLUSH_VAL, 3'b000, 2'b11, K_PUSH | K_IV);
    run(TT_CLEAN_VAL, 3'b111, 2'b10, 13'h0000);
    run(TT_CLEAN_VAL, 3'b111, 2'b11, K_PUSH | K_CD);
    run(TT_KILL_VAL, 3'b000, 2'b10, K_IV);
    run(TT_KILL_VAL, 3'b000, 2'b11, K_IV);
    $display("test attribute table done");
    ctx(7'b0110000);
    care = K_FL | K_FC;
    run(TT_READ_VAL, 3'b011, 2'b00, K_FC);
    ctx(7'b1110000);
    run(TT_BWR_VAL, 3'b011, 2'b00, K_FL);
    ctx(7'b1000000);
    care = 13'h1fff;
    run(TT_READ_VAL, 3'b011, 2'b00, K_CL | K_CS);
    ctx(7'b0010001);
    care = K_FL | K_RS | K_CO;
    run(TT_READ_VAL, 3'b011, 2'b00, K_FL | K_RS | K_CO);
    ctx(7'b0000001);
    care = K_CL | K_AB;
    run(TT_READ_VAL, 3'b011, 2'b10, K_CL | K_AB);
    care = 13'h1fff;
    ctx(7'b0001010);
    run(TT_BWR_VAL, 3'b011, 2'b10, K_IV);
    run(TT_BWR_VAL, 3'b011, 2'b00, 13'h0000);
    ctx(7'b0001000);
    run(TT_BWR_VAL, 3'b011, 2'b00, 13'h0000);
    ctx(7'b0001110);
    run(TT_BWR_VAL, 3'b011, 2'b10, K_UP | K_CD);
    ctx(7'b0001100);
    run(TT_BWR_VAL, 3'b011, 2'b00, K_FL);
    ctx(7'b0000000);
    $display("test snoop and castout context done");
    data_bus_busy_i = 1'b1;
    run(TT_READ_VAL, 3'b011, 2'b10, K_CL);
    `CHK(n_addr_ack, 0)
    data_bus_busy_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    `CHK(n_addr_ack, 1)
    $display("test address ack hold-off done");
    final_report();
  end
endmodule // l2_cache_transaction_response_tb

// ---- verilog/l2_cache_transaction_response.sv ----
// response decision logic of a look-aside level-two cache
`timescale 1ns/1ps
module l2_cache_transaction_response (
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  input  wire logic                        transfer_start_i,
  input  wire logic [l2_resp_pkg::TT_W-1:0] transfer_type_code_i,
  input  wire logic                        burst_flag_n_i,
  input  wire logic                        cache_inhibit_n_i,
  input  wire logic                        write_through_n_i,
  input  wire logic                        tag_hit_i,
  input  wire logic                        tag_dirty_i,
  input  wire logic                        castout_hit_i,
  input  wire logic                        castout_full_i,
  input  wire logic                        victim_dirty_i,
  input  wire logic                        snoop_prev_i,
  input  wire logic                        snoop_was_read_i,
  input  wire logic                        snoop_was_hit_i,
  input  wire logic                        address_retry_i,
  input  wire logic                        data_bus_busy_i,
  input  wire logic                        bus_grant_i,
  input  wire logic [63:0]                 read_data_i,
  input  wire logic                        receiver_ready_i,
  output logic                             hit_claim_o,
  output logic                             address_acknowledge_o,
  output logic                             transfer_acknowledge_o,
  output logic                             address_retry_o,
  output logic                             cache_bus_request_o,
  output logic                             line_fill_o,
  output logic                             invalidate_o,
  output logic                             update_o,
  output logic                             clear_dirty_o,
  output logic                             writeback_o,
  output logic                             castout_supply_o,
  output logic                             fill_cancel_o,
  output logic                             restore_victim_o,
  output logic                             castout_invalidate_o,
  output logic                             read_abort_o,
  output logic [l2_resp_pkg::TT_W-1:0]     cb_type_code_o,
  output logic                             cb_burst_flag_n_o,
  output logic                             cb_cache_inhibit_n_o,
  output logic                             cb_write_through_n_o,
  output logic                             cb_drive_o,
  output logic [63:0]                      data_o,
  output logic                             data_valid_o
);
  import l2_resp_pkg::*;

  // pins are asynchronous to our logic: two stages each
  logic [10:0] s1;
  logic [10:0] s2;
  logic [TT_W-1:0] tt1;
  logic [TT_W-1:0] tt2;
  wire  [10:0] pin_raw = {transfer_start_i, burst_flag_n_i, cache_inhibit_n_i,
                          write_through_n_i, address_retry_i, data_bus_busy_i,
                          bus_grant_i, snoop_prev_i, snoop_was_read_i,
                          snoop_was_hit_i, castout_full_i};
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s1  <= '0;
      s2  <= '0;
      tt1 <= '0;
      tt2 <= '0;
    end else begin
      s1  <= pin_raw;
      s2  <= s1;
      tt1 <= transfer_type_code_i;
      tt2 <= tt1;
    end
  end
  wire ts        = s2[10];
  wire burst_n   = s2[9];
  wire inh_n     = s2[8];
  wire wt_n      = s2[7];
  wire retry_in  = s2[6];
  wire dbusy     = s2[5];
  wire grant     = s2[4];
  wire snp_prev  = s2[3];
  wire snp_read  = s2[2];
  wire snp_hit   = s2[1];
  wire cob_full  = s2[0];

  function automatic logic tt_match(input logic [4:0] code, input logic [4:0] val,
                                    input logic [4:0] care);
    tt_match = ((code ^ val) & care) == 5'h00;
  endfunction

  wire hit   = tag_hit_i;
  wire clean = tag_hit_i && !tag_dirty_i;
  wire dirty = tag_hit_i && tag_dirty_i;
  wire m_read  = tt_match(tt2, TT_READ_VAL, TT_READ_CARE) && !burst_n && inh_n;
  wire m_ncrd  = tt_match(tt2, TT_NCRD_VAL, TT_NCRD_CARE) && burst_n && !inh_n;
  wire m_bwr   = tt_match(tt2, TT_BWR_VAL, TT_ALL_CARE) && !burst_n && inh_n;
  wire m_wt    = tt_match(tt2, TT_WT_VAL, TT_WT_CARE) && inh_n && !wt_n;
  wire m_swr   = tt_match(tt2, TT_SWR_VAL, TT_ALL_CARE) && burst_n && inh_n && !wt_n;
  wire m_ncwr  = tt_match(tt2, TT_NCWR_VAL, TT_NCWR_CARE) && burst_n && !inh_n;
  wire m_flush = tt_match(tt2, TT_FLUSH_VAL, TT_ALL_CARE);
  wire m_clean = tt_match(tt2, TT_CLEAN_VAL, TT_ALL_CARE);
  wire m_kill  = tt_match(tt2, TT_KILL_VAL, TT_ALL_CARE);
  wire after_snoop_wr = snp_prev && !snp_read;
  wire after_snoop_rd = snp_prev && snp_read;
  // a dirty victim with a full buffer cannot be evicted unless castout_hit_i is set
  wire fill_blocked = victim_dirty_i && cob_full && !castout_hit_i;

  logic [3:0] next_act;
  always_comb begin
    next_act = ACT_NONE;
    if (m_read && !hit && castout_hit_i)
      next_act = ACT_COB_SUPPLY;
    else if (m_read && !hit)
      next_act = fill_blocked ? ACT_FILL_CANCEL : ACT_FILL;
    else if (m_read && hit)
      next_act = ACT_CLAIM;
    else if (m_ncrd && clean)
      next_act = ACT_INVAL;
    else if (m_ncrd && dirty)
      next_act = ACT_PUSH_INVAL;
    else if (m_bwr && after_snoop_wr && snp_hit && hit)
      next_act = ACT_INVAL;
    else if (m_bwr && after_snoop_wr && !snp_hit && !hit)
      next_act = ACT_NONE;
    else if (m_bwr && after_snoop_rd && snp_hit && hit)
      next_act = ACT_UPD_CLR;
    else if (m_bwr && !hit && !(snp_prev && snp_hit))
      next_act = fill_blocked ? ACT_FILL_CANCEL : ACT_FILL;
    else if (m_bwr && dirty && !wt_n)
      next_act = ACT_UPD_CLR;
    else if (m_swr && dirty)
      next_act = ACT_PUSH_KEEP;
    else if (m_wt && clean)
      next_act = ACT_UPDATE;
    else if (m_ncwr && clean)
      next_act = ACT_INVAL;
    else if (m_ncwr && dirty)
      next_act = ACT_PUSH_INVAL;
    else if (m_flush && clean)
      next_act = ACT_INVAL;
    else if (m_flush && dirty)
      next_act = ACT_PUSH_INVAL;
    else if (m_clean && dirty)
      next_act = ACT_PUSH_KEEP;
    else if (m_kill && hit)
      next_act = ACT_INVAL;
  end

  typedef enum logic [2:0] {S_IDLE, S_DECIDE, S_CLAIM, S_DATA, S_PUSH, S_FILL} state_t;
  state_t state;
  logic   ts_d;
  logic   [1:0] beat;
  logic   fill_dirty;
  wire    ts_rise = ts && !ts_d;
  wire    beat_go;
  wire    buf_ready;

  // read data passes through the buffer so a stalled receiver loses no beat
  assign beat_go = (state == S_DATA) && buf_ready && !retry_in;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state                 <= S_IDLE;
      ts_d                  <= 1'b0;
      beat                  <= 2'h0;
      fill_dirty            <= 1'b0;
      hit_claim_o           <= 1'b0;
      address_acknowledge_o <= 1'b0;
      transfer_acknowledge_o <= 1'b0;
      address_retry_o       <= 1'b0;
      cache_bus_request_o   <= 1'b0;
      line_fill_o           <= 1'b0;
      invalidate_o          <= 1'b0;
      update_o              <= 1'b0;
      clear_dirty_o         <= 1'b0;
      writeback_o           <= 1'b0;
      castout_supply_o      <= 1'b0;
      fill_cancel_o         <= 1'b0;
      restore_victim_o      <= 1'b0;
      castout_invalidate_o  <= 1'b0;
      read_abort_o          <= 1'b0;
      cb_type_code_o        <= '0;
      cb_burst_flag_n_o     <= 1'b1;
      cb_cache_inhibit_n_o  <= 1'b1;
      cb_write_through_n_o  <= 1'b1;
      cb_drive_o            <= 1'b0;
    end else begin
      ts_d                  <= ts;
      address_acknowledge_o <= 1'b0;
      transfer_acknowledge_o <= 1'b0;
      address_retry_o       <= 1'b0;
      line_fill_o           <= 1'b0;
      invalidate_o          <= 1'b0;
      update_o              <= 1'b0;
      clear_dirty_o         <= 1'b0;
      writeback_o           <= 1'b0;
      castout_supply_o      <= 1'b0;
      fill_cancel_o         <= 1'b0;
      restore_victim_o      <= 1'b0;
      castout_invalidate_o  <= 1'b0;
      read_abort_o          <= 1'b0;
      case (state)
        S_IDLE: begin
          if (ts_rise)
            state <= S_DECIDE;
        end
        S_DECIDE: begin
          state <= S_IDLE;
          case (action_t'(next_act))
            ACT_FILL: begin
              line_fill_o <= 1'b1;
              fill_dirty  <= victim_dirty_i;
              state       <= S_FILL;
            end
            ACT_FILL_CANCEL: fill_cancel_o <= 1'b1;
            ACT_CLAIM, ACT_COB_SUPPLY: begin
              hit_claim_o      <= 1'b1;
              castout_supply_o <= (next_act == 4'(ACT_COB_SUPPLY));
              state            <= S_CLAIM;
            end
            ACT_INVAL: invalidate_o <= 1'b1;
            ACT_UPDATE: update_o <= 1'b1;
            ACT_UPD_CLR: begin
              update_o      <= 1'b1;
              clear_dirty_o <= 1'b1;
            end
            ACT_PUSH_INVAL, ACT_PUSH_KEEP: begin
              address_retry_o     <= 1'b1;
              cache_bus_request_o <= 1'b1;
              fill_dirty          <= (next_act == 4'(ACT_PUSH_INVAL));
              state               <= S_PUSH;
            end
            default: state <= S_IDLE;
          endcase
        end
        S_CLAIM: begin
          if (retry_in) begin
            hit_claim_o  <= 1'b0;
            read_abort_o <= 1'b1;
            state        <= S_IDLE;
          end else if (!dbusy) begin
            address_acknowledge_o <= 1'b1;
            beat                  <= 2'h0;
            state                 <= S_DATA;
          end
        end
        S_DATA: begin
          if (retry_in) begin
            hit_claim_o  <= 1'b0;
            read_abort_o <= 1'b1;
            state        <= S_IDLE;
          end else if (beat_go) begin
            transfer_acknowledge_o <= 1'b1;
            beat                   <= beat + 2'h1;
            if (beat == BEAT_LAST) begin
              hit_claim_o <= 1'b0;
              state       <= S_IDLE;
            end
          end
        end
        S_FILL: begin
          // retry window: one cycle after the fill decision
          if (retry_in && fill_dirty) begin
            fill_cancel_o        <= 1'b1;
            restore_victim_o     <= 1'b1;
            castout_invalidate_o <= 1'b1;
          end
          state <= S_IDLE;
        end
        S_PUSH: begin
          if (grant) begin
            cache_bus_request_o  <= 1'b0;
            writeback_o          <= 1'b1;
            cb_drive_o           <= 1'b1;
            cb_type_code_o       <= TT_CB_VAL;
            cb_burst_flag_n_o    <= CB_BURST_N;
            cb_cache_inhibit_n_o <= CB_INHIBIT_N;
            cb_write_through_n_o <= CB_WT_N;
            invalidate_o         <= fill_dirty;
            clear_dirty_o        <= !fill_dirty;
            state                <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
      if (state != S_PUSH)
        cb_drive_o <= 1'b0;
    end
  end

  logic [63:0] buf_data;
  logic        buf_valid;
  resp_buffer u_buf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_data_i   (read_data_i),
    .in_valid_i  (beat_go),
    .in_ready_o  (buf_ready),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (receiver_ready_i)
  );
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_o       <= '0;
      data_valid_o <= 1'b0;
    end else begin
      data_o       <= buf_data;
      data_valid_o <= buf_valid && receiver_ready_i;
    end
  end

  a_ack_after_claim: assert property (@(posedge clk_i) disable iff (reset_i)
    address_acknowledge_o |-> hit_claim_o && $past(state == S_CLAIM) && !$past(dbusy))
    else $error("address ack without claim or with busy data bus");
  a_ta_needs_claim: assert property (@(posedge clk_i) disable iff (reset_i)
    transfer_acknowledge_o |-> hit_claim_o || $past(hit_claim_o))
    else $error("data ack without hit claim");
  a_retry_aborts: assert property (@(posedge clk_i) disable iff (reset_i)
    (retry_in && (state == S_CLAIM || state == S_DATA)) |=> read_abort_o && !hit_claim_o)
    else $error("retry did not abort read service");
  a_restore_set: assert property (@(posedge clk_i) disable iff (reset_i)
    restore_victim_o |-> fill_cancel_o && castout_invalidate_o)
    else $error("victim restore without cancel");
  a_push_retry: assert property (@(posedge clk_i) disable iff (reset_i)
    (state == S_DECIDE && next_act == 4'(ACT_PUSH_INVAL)) |=> address_retry_o
      && cache_bus_request_o)
    else $error("dirty push not retried");
  a_cb_attrs: assert property (@(posedge clk_i) disable iff (reset_i)
    writeback_o |-> cb_type_code_o == TT_CB_VAL && !cb_burst_flag_n_o
      && cb_cache_inhibit_n_o && cb_write_through_n_o)
    else $error("copy-back attributes wrong");
  a_kill_no_wb: assert property (@(posedge clk_i) disable iff (reset_i)
    (state == S_DECIDE && m_kill && hit) |=> invalidate_o && !address_retry_o)
    else $error("kill did not invalidate cleanly");
  a_fill_blocked: assert property (@(posedge clk_i) disable iff (reset_i)
    (state == S_DECIDE && m_read && !hit && fill_blocked && !castout_hit_i)
      |=> fill_cancel_o && !line_fill_o)
    else $error("blocked fill went ahead");
endmodule // l2_cache_transaction_response

// ---- verilog/l2_resp_pkg.sv ----
// shared constants and types for the cache transaction response logic
package l2_resp_pkg;
  localparam int TT_W = 5;
  localparam logic [4:0] TT_READ_VAL  = 5'h0a; // x1x10
  localparam logic [4:0] TT_READ_CARE = 5'h0b;
  localparam logic [4:0] TT_NCRD_VAL  = 5'h0a; // x1010
  localparam logic [4:0] TT_NCRD_CARE = 5'h0f;
  localparam logic [4:0] TT_BWR_VAL   = 5'h06; // 00110
  localparam logic [4:0] TT_WT_VAL    = 5'h02; // 00x10
  localparam logic [4:0] TT_WT_CARE   = 5'h1b;
  localparam logic [4:0] TT_SWR_VAL   = 5'h02; // 00010
  localparam logic [4:0] TT_NCWR_VAL  = 5'h02; // x0010
  localparam logic [4:0] TT_NCWR_CARE = 5'h0f;
  localparam logic [4:0] TT_FLUSH_VAL = 5'h04; // 00100
  localparam logic [4:0] TT_CLEAN_VAL = 5'h00; // 00000
  localparam logic [4:0] TT_KILL_VAL  = 5'h0c; // 01100
  localparam logic [4:0] TT_ALL_CARE  = 5'h1f;
  localparam logic [4:0] TT_CB_VAL    = 5'h02; // copy-back write
  localparam logic       CB_BURST_N   = 1'b0;
  localparam logic       CB_INHIBIT_N = 1'b1;
  localparam logic       CB_WT_N      = 1'b1;
  localparam int         BUF_DEPTH    = 2;
  localparam int         BEATS        = 4;
  localparam logic [1:0] BEAT_LAST    = 2'h3;

  typedef enum logic [3:0] {
    ACT_NONE, ACT_FILL, ACT_CLAIM, ACT_INVAL, ACT_UPDATE, ACT_UPD_CLR,
    ACT_PUSH_INVAL, ACT_PUSH_KEEP, ACT_COB_SUPPLY, ACT_FILL_CANCEL
  } action_t;
endpackage

// ---- verilog/resp_buffer.sv ----
// two-entry valid/ready buffer for read data beats
`timescale 1ns/1ps
module resp_buffer (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [63:0] in_data_i,
  input  wire logic        in_valid_i,
  output logic             in_ready_o,
  output logic [63:0]      out_data_o,
  output logic             out_valid_o,
  input  wire logic        out_ready_i
);
  import l2_resp_pkg::*;
  logic [63:0] mem [BUF_DEPTH];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;
  wire         push = in_valid_i && (count != 2'(BUF_DEPTH));
  wire         pop  = out_ready_i && (count != 2'h0);

  assign in_ready_o  = (count != 2'(BUF_DEPTH));
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = mem[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + 2'(push) - 2'(pop);
    end
  end

  // no overflow: a push never happens while full
  a_buf_no_over: assert property (@(posedge clk_i) disable iff (reset_i)
    (count == 2'h2 && !pop) |=> count == 2'h2)
    else $error("buffer count changed while full and idle");
endmodule // resp_buffer
